//--- rtl/drive_load_supervision.sv
`timescale 1ns/1ps

module drive_load_supervision #(
   parameter int TENTH_CYCLES = drive_supervision_pkg::TENTH_MS
                              * drive_supervision_pkg::CLK_KHZ
) (
   input  wire logic                            clk,
   input  wire logic                            arst_n,
   input  wire logic                            vector_mode,
   input  wire logic                            running,
   input  wire logic                            at_speed,
   input  wire logic [7:0]                      current_pct,
   input  wire logic [7:0]                      torque_pct,
   input  wire logic                            detection_basis_select,
   input  wire drive_supervision_pkg::ut_cfg_t  ut_cfg,
   input  wire logic [7:0]                      multi_output_select_a,
   input  wire logic [7:0]                      multi_output_select_b,
   input  wire logic [7:0]                      multi_output_select_c,
   input  wire logic                            fault_reset,
   input  wire logic                            remote_mode,
   input  wire logic                            reference_loss_select,
   input  wire logic [3:0]                      frequency_source_select,
   input  wire logic [15:0]                     ref_level,
   input  wire logic [7:0]                      input_imbalance_pct,
   input  wire drive_supervision_pkg::op_cfg_t  input_op_cfg,
   input  wire logic [7:0]                      output_imbalance_pct,
   input  wire drive_supervision_pkg::op_cfg_t  output_op_cfg,
   output logic [2:0]                           multi_output,
   output logic                                 undertorque_detected,
   output logic                                 indication_flash,
   output logic                                 indication_lit,
   output logic                                 drive_stop,
   output logic                                 ref_loss_active,
   output logic [15:0]                          ref_out,
   output logic                                 input_open_phase_fault,
   output logic                                 output_open_phase_fault
);

   localparam int PW = $clog2(TENTH_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////
   // Shared tenth-of-a-second time base.

   logic [PW-1:0] presc;
   logic [PW-1:0] next_presc;
   logic          tick;

   // The prescaler wraps once per tenth and pulses tick.
   always_comb begin
      tick       = (presc == PW'(TENTH_CYCLES - 1));
      next_presc = tick ? '0 : presc + 1'b1;
   end

   // Prescaler register.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         presc <= '0;
      end else begin
         presc <= next_presc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Undertorque detector.

   drive_supervision_pkg::ut_state_t state;
   drive_supervision_pkg::ut_state_t next_state;
   logic [8:0] ut_cnt;
   logic [8:0] next_ut_cnt;
   logic       ut_fault;
   logic       next_ut_fault;
   logic [7:0] ut_meas;
   logic       ut_active;
   logic       ut_below;
   logic       ut_release;
   logic       ut_stop_mode;
   logic       ut_cont_mode;

   // Pick the basis, qualify by mode, then time the low load.
   always_comb begin
      ut_meas = (vector_mode && !detection_basis_select) ?
                torque_pct : current_pct;
      case (ut_cfg.function_select)
         drive_supervision_pkg::UT_SPD_ALARM,
         drive_supervision_pkg::UT_SPD_FAULT: ut_active = running && at_speed;
         drive_supervision_pkg::UT_RUN_ALARM,
         drive_supervision_pkg::UT_RUN_FAULT: ut_active = running;
         default:                             ut_active = 1'b0;
      endcase
      ut_stop_mode = (ut_cfg.function_select ==
                      drive_supervision_pkg::UT_SPD_FAULT) ||
                     (ut_cfg.function_select ==
                      drive_supervision_pkg::UT_RUN_FAULT);
      ut_cont_mode = (ut_cfg.function_select ==
                      drive_supervision_pkg::UT_SPD_ALARM) ||
                     (ut_cfg.function_select ==
                      drive_supervision_pkg::UT_RUN_ALARM);
      ut_below   = ut_active && (ut_meas < ut_cfg.level);
      ut_release = ({1'b0, ut_meas} >= ({1'b0, ut_cfg.level}
                    + drive_supervision_pkg::UT_HYST_PCT));
      next_state  = state;
      next_ut_cnt = ut_cnt;
      case (state)
         drive_supervision_pkg::UT_IDLE: begin
            next_ut_cnt = '0;
            if (ut_below) begin
               next_state = drive_supervision_pkg::UT_TIMING;
            end
         end
         drive_supervision_pkg::UT_TIMING: begin
            if (!ut_below) begin
               next_state = drive_supervision_pkg::UT_IDLE;
            end else if (ut_cnt > {1'b0, ut_cfg.time_tenths}) begin
               next_state = drive_supervision_pkg::UT_DETECTED;
            end else if (tick && ut_cnt != 9'h1FF) begin
               next_ut_cnt = ut_cnt + 9'h001;
            end
         end
         drive_supervision_pkg::UT_DETECTED: begin
            if (ut_release || ut_cfg.function_select == 3'h0) begin
               next_state = drive_supervision_pkg::UT_IDLE;
            end
         end
         default: next_state = drive_supervision_pkg::UT_IDLE;
      endcase
      // A new detection wins over a simultaneous fault reset.
      next_ut_fault = (ut_fault && !fault_reset) ||
                      (next_state == drive_supervision_pkg::UT_DETECTED &&
                       state != drive_supervision_pkg::UT_DETECTED &&
                       ut_stop_mode);
   end

   // Undertorque registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= drive_supervision_pkg::UT_IDLE;
         ut_cnt   <= '0;
         ut_fault <= 1'b0;
      end else begin
         state    <= next_state;
         ut_cnt   <= next_ut_cnt;
         ut_fault <= next_ut_fault;
      end
   end

   // Indications follow the detector state and the latched fault.
   assign undertorque_detected = (state == drive_supervision_pkg::UT_DETECTED);
   assign indication_flash     = undertorque_detected && ut_cont_mode;
   assign indication_lit       = ut_fault;
   assign drive_stop           = ut_fault || input_open_phase_fault ||
                                 output_open_phase_fault;

   ////////////////////////////////////////////////////////////////////////
   // Multi-function output contacts.

   logic [7:0] mo_sel [3];
   assign mo_sel[0] = multi_output_select_a;
   assign mo_sel[1] = multi_output_select_b;
   assign mo_sel[2] = multi_output_select_c;

   // Each contact carries undertorque as NO or NC, else stays open.
   for (genvar i = 0; i < 3; i++) begin : g_mo
      assign multi_output[i] =
         (mo_sel[i] == drive_supervision_pkg::MO_UT_NO) ? undertorque_detected
       : (mo_sel[i] == drive_supervision_pkg::MO_UT_NC) ? !undertorque_detected
       : 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency reference loss.

   logic [15:0] snap;
   logic [15:0] next_snap;
   logic [15:0] hold;
   logic [15:0] next_hold;
   logic [1:0]  win;
   logic [1:0]  next_win;
   logic        next_loss;
   logic [15:0] next_ref_out;
   logic        ref_en;
   logic        ref_drop;
   logic [19:0] hold_calc;

   // Snapshot every window while no loss is active; a collapse to a tenth or less holds 80 percent.
   always_comb begin
      ref_en = reference_loss_select && remote_mode &&
               ((frequency_source_select >=
                 drive_supervision_pkg::FSRC_ANALOG_LO &&
                 frequency_source_select <=
                 drive_supervision_pkg::FSRC_ANALOG_HI) ||
                frequency_source_select ==
                drive_supervision_pkg::FSRC_PULSE);
      ref_drop  = (snap != 16'h0000) &&
                  (20'(ref_level) * drive_supervision_pkg::REF_DROP_MUL
                   <= 20'(snap));
      hold_calc = 20'(snap) * drive_supervision_pkg::REF_HOLD_NUM
                  / drive_supervision_pkg::REF_HOLD_DEN;
      next_win  = win;
      next_snap = snap;
      if (tick) begin
         if (win == 2'(drive_supervision_pkg::REF_WIN_LAST)) begin
            next_win  = 2'h0;
            next_snap = ref_level;
         end else begin
            next_win = win + 2'h1;
         end
      end
      next_hold = hold;
      next_loss = ref_loss_active;
      if (!ref_en) begin
         next_loss = 1'b0;
      end else if (!ref_loss_active && ref_drop) begin
         next_loss = 1'b1;
         next_hold = hold_calc[15:0];
         next_snap = snap; // Freeze the pre-drop level.
      end else if (ref_loss_active && ref_level >= hold) begin
         next_loss = 1'b0;
      end
      if (ref_loss_active) begin
         next_snap = snap;
      end
      next_ref_out = next_loss ? next_hold : ref_level;
   end

   // Reference-loss registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         snap            <= '0;
         hold            <= '0;
         win             <= '0;
         ref_loss_active <= 1'b0;
         ref_out         <= '0;
      end else begin
         snap            <= next_snap;
         hold            <= next_hold;
         win             <= next_win;
         ref_loss_active <= next_loss;
         ref_out         <= next_ref_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input and output open-phase detectors.

   logic [7:0]  op_meas  [2];
   logic [7:0]  op_level [2];
   logic [7:0]  op_time  [2];
   logic [3:0]  op_unit  [2];
   logic [11:0] op_cnt   [2];
   logic [1:0]  op_cond;
   logic [1:0]  op_fault;

   assign op_meas[0]  = input_imbalance_pct;
   assign op_level[0] = input_op_cfg.level;
   assign op_time[0]  = input_op_cfg.time_steps;
   assign op_unit[0]  = drive_supervision_pkg::IN_OP_TENTHS_PER_STEP;
   assign op_meas[1]  = output_imbalance_pct;
   assign op_level[1] = output_op_cfg.level;
   assign op_time[1]  = output_op_cfg.time_steps;
   assign op_unit[1]  = drive_supervision_pkg::OUT_OP_TENTHS_PER_STEP;
   assign input_open_phase_fault  = op_fault[0];
   assign output_open_phase_fault = op_fault[1];

   for (genvar j = 0; j < 2; j++) begin : g_op
      logic [11:0] limit;
      logic [11:0] next_cnt;
      logic        next_fault;

      // Persisting imbalance for the set time latches the fault.
      always_comb begin
         limit      = 12'(op_time[j]) * 12'(op_unit[j]);
         op_cond[j] = (op_level[j] != 8'h00) && (op_time[j] != 8'h00) &&
                      (op_meas[j] >= op_level[j]);
         next_cnt   = '0;
         if (op_cond[j]) begin
            next_cnt = (tick && op_cnt[j] != 12'hFFF) ?
                       op_cnt[j] + 12'h001 : op_cnt[j];
         end
         next_fault = (op_fault[j] && !fault_reset) ||
                      (op_cond[j] && op_cnt[j] >= limit);
      end

      // Open-phase registers.
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            op_cnt[j]   <= '0;
            op_fault[j] <= 1'b0;
         end else begin
            op_cnt[j]   <= next_cnt;
            op_fault[j] <= next_fault;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_mo_nc_contact: assert property (
      multi_output_select_b == drive_supervision_pkg::MO_UT_NC
      |-> multi_output[1] != undertorque_detected)
      else $error("NC contact does not invert undertorque.");
   a_ut_hyst_hold: assert property (
      undertorque_detected && !ut_release && ut_cfg.function_select != 3'h0
      |=> undertorque_detected)
      else $error("Undertorque released inside hysteresis.");
   a_ut_mode_off: assert property (
      ut_cfg.function_select == 3'h0 [*2] |-> !undertorque_detected)
      else $error("Undertorque detected while disabled.");
   a_ut_alarm_flash: assert property (
      undertorque_detected && ut_cont_mode |-> indication_flash)
      else $error("Continue mode does not flash.");
   a_ut_fault_stop: assert property (
      $rose(undertorque_detected) && ut_stop_mode
      |-> indication_lit && drive_stop)
      else $error("Stop mode did not latch fault.");
   a_ut_time_met: assert property (
      $rose(undertorque_detected)
      |-> $past(ut_below) && $past(ut_cnt) > 9'($past(ut_cfg.time_tenths)))
      else $error("Undertorque declared too early.");
   a_ref_loss_gate: assert property (
      !reference_loss_select || !remote_mode |=> !ref_loss_active)
      else $error("Reference loss active while not enabled.");
   a_ref_hold_value: assert property (
      $rose(ref_loss_active)
      |-> 20'(ref_out) == 20'($past(snap)) * 20'h0_0004 / 20'h0_0005)
      else $error("Held reference is not four fifths.");
   a_op_disabled: assert property (
      input_op_cfg.level == 8'h00 || input_op_cfg.time_steps == 8'h00
      |=> op_cnt[0] == 12'h000)
      else $error("Disabled open-phase detector is timing.");
   a_op_timer_clear: assert property (
      !op_cond[1] |=> op_cnt[1] == 12'h000 && !$rose(op_fault[1]))
      else $error("Open-phase timer not cleared.");
   a_vf_basis: assert property (
      !vector_mode |-> ut_meas == current_pct)
      else $error("V/f mode not using current.");

   c_ut_detect: cover property ($rose(undertorque_detected));
   c_ut_release: cover property ($fell(undertorque_detected));
   c_ref_loss: cover property ($rose(ref_loss_active));
   c_op_fault: cover property ($rose(input_open_phase_fault));

endmodule // drive_load_supervision

//--- rtl/drive_supervision_pkg.sv
package drive_supervision_pkg;

   // Clock rate and the supervision time base.
   localparam int CLK_KHZ            = 20_000;
   localparam int TENTH_MS           = 100;
   localparam int REF_LOSS_WINDOW_MS = 400;
   localparam int REF_LOSS_TENTHS    = REF_LOSS_WINDOW_MS / TENTH_MS;
   localparam int REF_WIN_LAST       = REF_LOSS_TENTHS - 1;

   // Open-phase time units, in tenths of a second per setting step.
   localparam logic [3:0] IN_OP_TENTHS_PER_STEP  = 4'hA;
   localparam logic [3:0] OUT_OP_TENTHS_PER_STEP = 4'h1;

   // Multi-function output selections.
   localparam logic [7:0] MO_UT_NO = 8'h08;
   localparam logic [7:0] MO_UT_NC = 8'h09;

   // Undertorque release hysteresis, percent of rated current or torque, as the detection basis selects.
   localparam logic [8:0] UT_HYST_PCT = 9'h005;

   // Reference loss: drop to a tenth, continue at four fifths.
   localparam logic [19:0] REF_DROP_MUL = 20'h0_000A;
   localparam logic [19:0] REF_HOLD_NUM = 20'h0_0004;
   localparam logic [19:0] REF_HOLD_DEN = 20'h0_0005;

   // Frequency source codes that carry an analog or pulse reference.
   localparam logic [3:0] FSRC_ANALOG_LO = 4'h2;
   localparam logic [3:0] FSRC_ANALOG_HI = 4'h4;
   localparam logic [3:0] FSRC_PULSE     = 4'h6;

   // Undertorque function selections.
   typedef enum logic [2:0] {
      UT_OFF       = 3'h0,
      UT_SPD_ALARM = 3'h1,
      UT_SPD_FAULT = 3'h2,
      UT_RUN_ALARM = 3'h3,
      UT_RUN_FAULT = 3'h4
   } ut_mode_t;

   // Undertorque detector states, Gray coded along the path.
   typedef enum logic [1:0] {
      UT_IDLE     = 2'h0,
      UT_TIMING   = 2'h1,
      UT_DETECTED = 2'h3
   } ut_state_t;

   // Undertorque settings: level in percent, time in tenths of a second.
   typedef struct packed {
      logic [2:0] function_select;
      logic [7:0] level;
      logic [7:0] time_tenths;
   } ut_cfg_t;

   // Open-phase settings: level in percent, time in setting steps.
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] time_steps;
   } op_cfg_t;

endpackage

//--- tb/drive_sense_model.sv
`timescale 1ns/1ps

// Sensing front end and reference source in front of the supervision block.
module drive_sense_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic [7:0]  want_cur,
   input  wire logic [7:0]  want_trq,
   input  wire logic [15:0] want_ref,
   input  wire logic [7:0]  want_iimb,
   input  wire logic [7:0]  want_oimb,
   output logic      [7:0]  current_pct,
   output logic      [7:0]  torque_pct,
   output logic      [15:0] ref_level,
   output logic      [7:0]  input_imbalance_pct,
   output logic      [7:0]  output_imbalance_pct
);
   logic [47:0] first;
   logic [47:0] second;

   ////////////////////////////////////////////////////////////////////////
   // Commands are sampled on the rising edge, where they are stable.
   always @(posedge clk) begin
      first  <= {want_cur, want_trq, want_ref, want_iimb, want_oimb};
      second <= first;
   end

   // Sensed values appear on the falling edge; slow mode adds a cycle.
   always @(negedge clk) begin
      {current_pct, torque_pct, ref_level, input_imbalance_pct,
       output_imbalance_pct} <= slow ? second : first;
   end
endmodule // drive_sense_model

//--- tb/drive_load_supervision_bench.sv
`timescale 1ns/1ps

`define CHECK(nm, exp, got) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
   end \
end

// Self-checking bench for the load supervision block.
module drive_load_supervision_bench;
   logic                             clk;
   logic                             arst_n;
   logic                             vector_mode;
   logic                             running;
   logic                             at_speed;
   logic                             detection_basis_select;
   logic                             fault_reset;
   logic                             remote_mode;
   logic                             reference_loss_select;
   logic [3:0]                       frequency_source_select;
   logic                             slow;
   logic [7:0]                       want_cur;
   logic [7:0]                       want_trq;
   logic [15:0]                      want_ref;
   logic [7:0]                       want_iimb;
   logic [7:0]                       want_oimb;
   logic [7:0]                       current_pct;
   logic [7:0]                       torque_pct;
   logic [15:0]                      ref_level;
   logic [7:0]                       input_imbalance_pct;
   logic [7:0]                       output_imbalance_pct;
   drive_supervision_pkg::ut_cfg_t   ut_cfg;
   drive_supervision_pkg::op_cfg_t   input_op_cfg;
   drive_supervision_pkg::op_cfg_t   output_op_cfg;
   logic [2:0]                       multi_output;
   logic                             undertorque_detected;
   logic                             indication_flash;
   logic                             indication_lit;
   logic                             drive_stop;
   logic                             ref_loss_active;
   logic [15:0]                      ref_out;
   logic                             input_open_phase_fault;
   logic                             output_open_phase_fault;
   int                               bad_count = 0;
   int                               cmp_count = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock of 50 ns period.
   initial clk = 1'b0;
   always #25 clk = ~clk;

   drive_sense_model sense (.clk(clk), .slow(slow), .want_cur(want_cur),
      .want_trq(want_trq), .want_ref(want_ref), .want_iimb(want_iimb),
      .want_oimb(want_oimb), .current_pct(current_pct),
      .torque_pct(torque_pct), .ref_level(ref_level),
      .input_imbalance_pct(input_imbalance_pct),
      .output_imbalance_pct(output_imbalance_pct));

   drive_load_supervision #(.TENTH_CYCLES(10)) uut (.clk(clk),
      .arst_n(arst_n), .vector_mode(vector_mode), .running(running),
      .at_speed(at_speed), .current_pct(current_pct),
      .torque_pct(torque_pct),
      .detection_basis_select(detection_basis_select), .ut_cfg(ut_cfg),
      .multi_output_select_a(drive_supervision_pkg::MO_UT_NO),
      .multi_output_select_b(drive_supervision_pkg::MO_UT_NC),
      .multi_output_select_c(8'h00), .fault_reset(fault_reset),
      .remote_mode(remote_mode),
      .reference_loss_select(reference_loss_select),
      .frequency_source_select(frequency_source_select),
      .ref_level(ref_level), .input_imbalance_pct(input_imbalance_pct),
      .input_op_cfg(input_op_cfg),
      .output_imbalance_pct(output_imbalance_pct),
      .output_op_cfg(output_op_cfg), .multi_output(multi_output),
      .undertorque_detected(undertorque_detected),
      .indication_flash(indication_flash),
      .indication_lit(indication_lit), .drive_stop(drive_stop),
      .ref_loss_active(ref_loss_active), .ref_out(ref_out),
      .input_open_phase_fault(input_open_phase_fault),
      .output_open_phase_fault(output_open_phase_fault));

   ////////////////////////////////////////////////////////////////////////
   // Every change of input happens just after a falling edge.
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Removes all fault conditions and clears the latched faults.
   task automatic clear_all();
      tick(1);
      want_cur = 8'h64;
      want_trq = 8'h64;
      want_iimb = 8'h00;
      want_oimb = 8'h00;
      ut_cfg.function_select = 3'h0;
      tick(4);
      fault_reset = 1'b1;
      tick(2);
      fault_reset = 1'b0;
      tick(3);
   endtask

   // One undertorque case; a stop fault must outlive its condition.
   task automatic ut_case(input logic [2:0] m, input logic spd, vec,
         basis, input logic [7:0] cur, trq, input logic det, lit);
      tick(1);
      ut_cfg.function_select = m;
      at_speed = spd;
      vector_mode = vec;
      detection_basis_select = basis;
      want_cur = cur;
      want_trq = trq;
      tick(60);
      `CHECK("undertorque_detected", det, undertorque_detected)
      `CHECK("indication_flash", det & ~lit, indication_flash)
      `CHECK("indication_lit", lit, indication_lit)
      want_cur = 8'h64;
      want_trq = 8'h64;
      tick(6);
      `CHECK("latched_stop", lit, drive_stop)
      clear_all();
      `CHECK("stop_after_reset", 1'b0, drive_stop)
   endtask

   // A 90 percent fall of the reference after a settled level.
   task automatic ref_case(input logic sel, rem, input logic [3:0] src,
         input logic [15:0] drop, input logic exp);
      tick(1);
      reference_loss_select = sel;
      remote_mode = rem;
      frequency_source_select = src;
      want_ref = 16'h03E8;
      tick(100);
      want_ref = drop;
      tick(4);
      `CHECK("ref_loss_active", exp, ref_loss_active)
      `CHECK("ref_out", exp ? 16'h0320 : drop, ref_out)
      want_ref = 16'h03E8;
      tick(4);
      `CHECK("ref_released", 1'b0, ref_loss_active)
   endtask

   // Open-phase case: quiet until lo cycles, then exp at hi cycles.
   task automatic op_case(input logic outp, input logic [7:0] lvl, tm,
         imb, input int lo, hi, input logic exp);
      tick(1);
      if (outp) begin
         output_op_cfg = '{lvl, tm};
         want_oimb = imb;
      end else begin
         input_op_cfg = '{lvl, tm};
         want_iimb = imb;
      end
      tick(lo);
      `CHECK("op_early", 1'b0, drive_stop)
      tick(hi - lo);
      `CHECK("op_fault", exp,
             outp ? output_open_phase_fault : input_open_phase_fault)
      `CHECK("op_stop", exp, drive_stop)
      clear_all();
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the expected length of the run.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      {arst_n, vector_mode, at_speed, detection_basis_select} = 4'h0;
      {fault_reset, remote_mode, reference_loss_select, slow} = 4'h0;
      running = 1'b1;
      frequency_source_select = 4'h0;
      {want_cur, want_trq, want_iimb, want_oimb} = 32'h6464_0000;
      want_ref = 16'h0000;
      ut_cfg = '{3'h0, 8'h0A, 8'h01};
      input_op_cfg = '{8'h00, 8'h00};
      output_op_cfg = '{8'h00, 8'h00};
      tick(20);
      `CHECK("reset_contacts", 3'b010, multi_output)
      `CHECK("reset_ref_out", 16'h0000, ref_out)
      arst_n = 1'b1;
      tick(5);
      at_speed = 1'b1;
      ut_cfg = '{3'h1, 8'h0A, 8'h03};
      want_cur = 8'h05;
      tick(28);
      `CHECK("ut_early", 1'b0, undertorque_detected)
      for (int i = 0; i < 30 && undertorque_detected !== 1'b1; i++) tick(1);
      `CHECK("ut_timed", 1'b1, undertorque_detected)
      `CHECK("contacts_on", 3'b001, multi_output)
      `CHECK("alarm_flash", 1'b1, indication_flash)
      `CHECK("alarm_runs", 1'b0, drive_stop)
      want_cur = 8'h0E;
      tick(6);
      `CHECK("ut_hyst_hold", 1'b1, undertorque_detected)
      want_cur = 8'h0F;
      tick(4);
      `CHECK("ut_hyst_free", 1'b0, undertorque_detected)
      `CHECK("contacts_off", 3'b010, multi_output)
      clear_all();
      ut_cfg.time_tenths = 8'h01;
      ut_case(3'h0, 1'b1, 1'b0, 1'b0, 8'h05, 8'h64, 1'b0, 1'b0);
      ut_case(3'h1, 1'b0, 1'b0, 1'b0, 8'h05, 8'h64, 1'b0, 1'b0);
      ut_case(3'h2, 1'b0, 1'b0, 1'b0, 8'h05, 8'h64, 1'b0, 1'b0);
      ut_case(3'h3, 1'b0, 1'b0, 1'b0, 8'h05, 8'h64, 1'b1, 1'b0);
      ut_case(3'h4, 1'b0, 1'b0, 1'b0, 8'h05, 8'h64, 1'b1, 1'b1);
      ut_case(3'h2, 1'b1, 1'b0, 1'b0, 8'h05, 8'h64, 1'b1, 1'b1);
      ut_case(3'h1, 1'b1, 1'b1, 1'b0, 8'h32, 8'h05, 1'b1, 1'b0);
      ut_case(3'h1, 1'b1, 1'b1, 1'b1, 8'h32, 8'h05, 1'b0, 1'b0);
      ut_case(3'h1, 1'b1, 1'b0, 1'b0, 8'h32, 8'h05, 1'b0, 1'b0);
      ref_case(1'b1, 1'b1, 4'h2, 16'h0065, 1'b0);
      ref_case(1'b1, 1'b1, 4'h2, 16'h0064, 1'b1);
      ref_case(1'b0, 1'b1, 4'h2, 16'h0064, 1'b0);
      ref_case(1'b1, 1'b0, 4'h3, 16'h0064, 1'b0);
      for (int s = 0; s < 8; s++) begin
         ref_case(1'b1, 1'b1, s[3:0], 16'h0064, s inside {2, 3, 4, 6});
      end
      op_case(1'b0, 8'h07, 8'h0A, 8'h08, 980, 1030, 1'b1);
      op_case(1'b1, 8'h05, 8'h02, 8'h06, 9, 35, 1'b1);
      op_case(1'b1, 8'h00, 8'h02, 8'hFF, 9, 60, 1'b0);
      op_case(1'b0, 8'h00, 8'h0A, 8'hFF, 9, 60, 1'b0);
      op_case(1'b1, 8'h05, 8'h00, 8'hFF, 9, 60, 1'b0);
      op_case(1'b0, 8'h07, 8'h00, 8'hFF, 9, 60, 1'b0);
      // Bursts shorter than one tick spacing drift across the time base,
      // so a timer that failed to clear would reach its limit.
      slow = 1'b1;
      output_op_cfg = '{8'h05, 8'h02};
      for (int k = 0; k < 4; k++) begin
         want_oimb = 8'h08;
         tick(9);
         want_oimb = 8'h00;
         tick(3);
      end
      `CHECK("op_bursts", 1'b0, output_open_phase_fault)
      print_verdict();
   end
endmodule // drive_load_supervision_bench
